// >>> ctsl_timer.sv
// One countdown timer slice with APB register access
`timescale 1ns/1ns
module ctsl_timer
  import ctsl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Events from the reader core, same clock
  input wire logic carrier_tick_i,
  input wire logic tx_end_i,
  input wire logic rx_first_nibble_i,
  input wire logic prev_underflow_i,
  input wire logic next_underflow_i,
  input wire logic [CNT_W-1:0] prev_count_i,
  // Trimming reference pin, asynchronous
  input wire logic trim_ref_i,
  // Timer status
  output logic underflow_o,
  output logic running_o,
  output logic underflow_irq_flag_o
);

  // Register state
  logic [7:0] control_q;
  logic [7:0] reload_high_q;
  logic [7:0] reload_low_q;
  logic [CNT_W-1:0] count_q;
  logic running_q;
  logic irq_flag_q;
  logic underflow_q;

  // APB answer state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Divider and synchroniser state
  logic [5:0] div_cnt_q;
  logic div_tick_q;
  logic trim_meta_q;
  logic trim_sync_q;
  logic trim_prev_q;

  // Decoded control fields
  ctsl_start_t start_sel;
  ctsl_clk_t clk_sel;
  logic stop_on_receive;
  logic auto_reload_enable;
  logic trim_mode;

  // Bus decode
  logic [7:0] reg_idx;
  logic addr_aligned;
  logic addr_hit;
  logic acc_done;
  logic wr_done;
  logic [7:0] rd_byte;

  // Timer events
  logic tick;
  logic trim_edge;
  logic sw_start;
  logic sw_stop;
  logic hw_start;
  logic hw_stop;
  logic at_zero;
  logic uf_event;

  assign start_sel = ctsl_start_t'(control_q[CTSL_CTL_START_HI:
                                              CTSL_CTL_START_LO]);
  assign clk_sel = ctsl_clk_t'(control_q[CTSL_CTL_CLK_HI:CTSL_CTL_CLK_LO]);
  assign stop_on_receive = control_q[CTSL_CTL_STOP_RX];
  assign auto_reload_enable = control_q[CTSL_CTL_AUTO_RELOAD];
  assign trim_mode = (start_sel == CTSL_START_TRIM) ||
                     (start_sel == CTSL_START_TRIM_UF);

  // Address decode: byte address is the index times four
  assign reg_idx = paddr_i[9:2];
  assign addr_aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[31:10] == '0);
  always_comb begin
    case (reg_idx)
      CTSL_IDX_START_STOP,
      CTSL_IDX_NB_CNT_HI,
      CTSL_IDX_NB_CNT_LO,
      CTSL_IDX_CONTROL,
      CTSL_IDX_RELOAD_HI,
      CTSL_IDX_RELOAD_LO,
      CTSL_IDX_CNT_HI,
      CTSL_IDX_CNT_LO,
      CTSL_IDX_IRQ_STATUS: addr_hit = addr_aligned;
      default: addr_hit = 1'b0;
    endcase
  end

  // Access completes at the edge where our registered pready is high
  assign acc_done = psel_i && penable_i && pready_q;
  assign wr_done = acc_done && pwrite_i && addr_hit;

  // Read mux; the count bytes are live and may tear during reception
  always_comb begin
    case (reg_idx)
      CTSL_IDX_START_STOP: begin
        rd_byte = 8'h00;
        rd_byte[CTSL_SS_RUNNING] = running_q; // [R20]
      end
      CTSL_IDX_NB_CNT_HI: rd_byte = prev_count_i[15:8]; // [R18]
      CTSL_IDX_NB_CNT_LO: rd_byte = prev_count_i[7:0]; // [R18]
      CTSL_IDX_CONTROL: rd_byte = control_q & CTSL_CTL_WR_MASK; // [R22]
      CTSL_IDX_RELOAD_HI: rd_byte = reload_high_q;
      CTSL_IDX_RELOAD_LO: rd_byte = reload_low_q;
      CTSL_IDX_CNT_HI: rd_byte = count_q[15:8]; // [R17]
      CTSL_IDX_CNT_LO: rd_byte = count_q[7:0]; // [R17]
      CTSL_IDX_IRQ_STATUS: rd_byte = {7'h00, irq_flag_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // APB answer: one wait state so every bus output leaves a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_hit;
      prdata_q <= (pwrite_i || !addr_hit) ? 32'h0000_0000
                                          : {24'h00_0000, rd_byte};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Control and reload bytes; reserved control bits never store
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      control_q <= CTSL_CTL_RESET;
      reload_high_q <= CTSL_RELOAD_RESET;
      reload_low_q <= CTSL_RELOAD_RESET;
    end else if (wr_done) begin
      case (reg_idx)
        CTSL_IDX_CONTROL: control_q <= pwdata_i[7:0] & CTSL_CTL_WR_MASK; // [R22]
        CTSL_IDX_RELOAD_HI: reload_high_q <= pwdata_i[7:0]; // [R16]
        CTSL_IDX_RELOAD_LO: reload_low_q <= pwdata_i[7:0]; // [R16]
        default: ;
      endcase
    end
  end

  // Carrier divider; ratio is exact, so no drift against the carrier
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      div_cnt_q <= 6'h00;
      div_tick_q <= 1'b0;
    end else begin
      div_tick_q <= 1'b0;
      if (carrier_tick_i) begin
        if (div_cnt_q == 6'(CTSL_DIV_RATIO - 1)) begin
          div_cnt_q <= 6'h00;
          div_tick_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 6'h01;
        end
      end
    end
  end

  // Trimming reference crosses in through two flip-flops
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trim_meta_q <= 1'b0;
      trim_sync_q <= 1'b0;
      trim_prev_q <= 1'b0;
    end else begin
      trim_meta_q <= trim_ref_i;
      trim_sync_q <= trim_meta_q;
      trim_prev_q <= trim_sync_q;
    end
  end
  assign trim_edge = trim_sync_q && !trim_prev_q;

  // Tick source selection
  always_comb begin
    case (clk_sel)
      CTSL_CLK_CARRIER: tick = carrier_tick_i; // [R11]
      CTSL_CLK_DIVIDED: tick = div_tick_q; // [R12]
      CTSL_CLK_PREV_UF: tick = prev_underflow_i; // [R13]
      CTSL_CLK_NEXT_UF: tick = next_underflow_i; // [R14]
      default: tick = 1'b0;
    endcase
  end

  // Start and stop requests
  assign sw_start = wr_done && (reg_idx == CTSL_IDX_START_STOP) &&
                    pwdata_i[CTSL_SS_MODIFY] &&
                    pwdata_i[CTSL_SS_RUNNING]; // [R20]
  assign sw_stop = wr_done && (reg_idx == CTSL_IDX_START_STOP) &&
                   pwdata_i[CTSL_SS_MODIFY] &&
                   !pwdata_i[CTSL_SS_RUNNING]; // [R20]
  // The transmit-end and both trimming modes start by themselves; mode zero never does
  assign hw_start = ((start_sel == CTSL_START_TX_END) && tx_end_i) || // [R04] [R05]
                    (trim_mode && trim_edge && !running_q); // [R06] [R07]
  // Receive stop only outside trimming modes
  assign hw_stop = running_q &&
                   ((stop_on_receive && !trim_mode && rx_first_nibble_i) || // [R01] [R02] [R03]
                    (trim_mode && trim_edge)); // [R06] [R07]

  assign at_zero = (count_q == '0);
  // Trimming without underflow holds at zero instead of wrapping
  assign uf_event = running_q && tick && at_zero &&
                    (start_sel != CTSL_START_TRIM); // [R06] [R21]

  // Counter and running state; software requests win over hardware events
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      count_q <= CTSL_COUNT_RESET;
      running_q <= 1'b0;
    end else if (sw_start || (hw_start && !sw_stop)) begin
      count_q <= {reload_high_q, reload_low_q}; // [R15]
      running_q <= 1'b1;
    end else if (sw_stop || hw_stop) begin
      running_q <= 1'b0;
    end else if (uf_event) begin
      if (auto_reload_enable) begin
        count_q <= {reload_high_q, reload_low_q}; // [R08]
      end else begin
        running_q <= 1'b0; // [R09]
      end
    end else if (running_q && tick && !at_zero) begin
      count_q <= count_q - CNT_W'(1); // [R21]
    end
  end

  // Underflow pulse for neighbours and the sticky flag; set beats clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      underflow_q <= 1'b0;
      irq_flag_q <= 1'b0;
    end else begin
      underflow_q <= uf_event;
      if (uf_event) begin
        irq_flag_q <= 1'b1; // [R10]
      end else if (wr_done && (reg_idx == CTSL_IDX_IRQ_STATUS) &&
                   pwdata_i[0]) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign underflow_o = underflow_q;
  assign running_o = running_q;
  assign underflow_irq_flag_o = irq_flag_q;

endmodule : ctsl_timer

// >>> ctsl_pkg.sv
// Package with register map, field layout and constants for the timer slice
// Operation
// (R01) Stop-on-receive set: halt countdown once receiver took first four bits.
// (R02) Stop-on-receive clear: reception never halts the timer.
// (R03) Trimming auto-start modes ignore the stop-on-receive bit.
// (R04) Auto-start zero: timer starts only by software.
// (R05) Auto-start one: timer starts when transmitter ends a frame.
// (R06) Auto-start two: trimming, no underflow, start/stop on reference edges.
// (R07) Auto-start three: trimming with underflow, start/stop on reference edges.
// (R08) Auto-reload set: at zero reload and keep counting.
// (R09) Auto-reload clear: count to zero and stop until next start.
// (R10) Each underflow sets the underflow interrupt flag.
// (R11) Clock select zero: count on carrier-frequency ticks.
// (R12) Clock select one: count on divided 211,875 kHz ticks.
// (R13) Clock select two: count on preceding timer underflows.
// (R14) Clock select three: count on following timer underflows.
// (R15) Every start event loads counter from the two reload bytes.
// (R16) Reload byte writes affect only the next start event.
// (R17) Live count readable as high and low bytes, read only.
// (R18) Preceding timer count readable as high and low bytes, read only.
// (R19) Host avoids reading count bytes while a frame is received.
// (R20) Running bit with modify-enable starts/stops; running bit reads status.
// (R21) Running counter decrements one per tick; underflow is step from zero.
// (R22) Control bits six and two read zero and ignore writes.
package ctsl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTSL_IDX_START_STOP = 8'h0e;
  localparam logic [7:0] CTSL_IDX_NB_CNT_HI = 8'h12;
  localparam logic [7:0] CTSL_IDX_NB_CNT_LO = 8'h13;
  localparam logic [7:0] CTSL_IDX_CONTROL = 8'h14;
  localparam logic [7:0] CTSL_IDX_RELOAD_HI = 8'h15;
  localparam logic [7:0] CTSL_IDX_RELOAD_LO = 8'h16;
  localparam logic [7:0] CTSL_IDX_CNT_HI = 8'h17;
  localparam logic [7:0] CTSL_IDX_CNT_LO = 8'h18;
  localparam logic [7:0] CTSL_IDX_IRQ_STATUS = 8'h20;

  // Control byte layout
  localparam int CTSL_CTL_STOP_RX = 7;
  localparam int CTSL_CTL_START_HI = 5;
  localparam int CTSL_CTL_START_LO = 4;
  localparam int CTSL_CTL_AUTO_RELOAD = 3;
  localparam int CTSL_CTL_CLK_HI = 1;
  localparam int CTSL_CTL_CLK_LO = 0;
  localparam logic [7:0] CTSL_CTL_WR_MASK = 8'hbb;

  // Shared start/stop byte layout
  localparam int CTSL_SS_RUNNING = 5;
  localparam int CTSL_SS_MODIFY = 1;

  // Reset values
  localparam logic [7:0] CTSL_CTL_RESET = 8'h00;
  localparam logic [7:0] CTSL_RELOAD_RESET = 8'h00;
  localparam logic [15:0] CTSL_COUNT_RESET = 16'h0000;

  // Carrier ticks per divided tick: 13.56 MHz / 211,875 kHz
  localparam int CTSL_DIV_RATIO = 64;

  // Auto-start modes
  typedef enum logic [1:0] {
    CTSL_START_SW = 2'b00,
    CTSL_START_TX_END = 2'b01,
    CTSL_START_TRIM = 2'b10,
    CTSL_START_TRIM_UF = 2'b11
  } ctsl_start_t;

  // Clock sources
  typedef enum logic [1:0] {
    CTSL_CLK_CARRIER = 2'b00,
    CTSL_CLK_DIVIDED = 2'b01,
    CTSL_CLK_PREV_UF = 2'b10,
    CTSL_CLK_NEXT_UF = 2'b11
  } ctsl_clk_t;

endpackage : ctsl_pkg

// >>> ctsl_timer_checker.sv
// Port-level assertions for the timer slice
`timescale 1ns/1ns
module ctsl_timer_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Events and status
  input wire logic tx_end_i,
  input wire logic rx_first_nibble_i,
  input wire logic trim_ref_i,
  input wire logic underflow_o,
  input wire logic running_o,
  input wire logic underflow_irq_flag_o
);
  logic wr_done;
  // Completed write; every change of run state needs a cause
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_one_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held high");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_byte_lane: assert property (pready_o && !pwrite_i |->
    prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  chk_flag_set: assert property (underflow_o |-> underflow_irq_flag_o)
    else $error("flag missing on underflow");
  chk_uf_running: assert property (underflow_o |-> $past(running_o))
    else $error("underflow while stopped");
  // Trimming reference acts three edges late, behind the synchroniser
  chk_start_cause: assert property ($rose(running_o) |->
    $past(wr_done) || $past(tx_end_i) || $past(trim_ref_i, 3))
    else $error("start without cause");
  chk_stop_cause: assert property ($fell(running_o) |->
    underflow_o || $past(rx_first_nibble_i) || $past(wr_done) ||
    $past(trim_ref_i, 3)) else $error("stop without cause");
  chk_flag_sticky: assert property ($fell(underflow_irq_flag_o) |->
    $past(wr_done && paddr_i == 32'h80)) else $error("flag lost");
  cover property (underflow_o);
  cover property ($fell(running_o) && !underflow_o);
  cover property (pslverr_o);
endmodule : ctsl_timer_checker

bind ctsl_timer ctsl_timer_checker chk_u (.ref_clk_i, .sys_rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .tx_end_i, .rx_first_nibble_i, .trim_ref_i, .underflow_o, .running_o,
  .underflow_irq_flag_o);

// >>> tb_ctsl_timer.sv
// Self-checking bench for the countdown timer slice
`timescale 1ns/1ns
module tb_ctsl_timer;
  import ctsl_pkg::*;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, carrier_tick_i = 1'b0, tx_end_i = 1'b0;
  logic rx_first_nibble_i = 1'b0, prev_underflow_i = 1'b0, err;
  logic next_underflow_i = 1'b0, trim_ref_i = 1'b0, pready_o, pslverr_o;
  logic underflow_o, running_o, underflow_irq_flag_o;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
  logic [15:0] prev_count_i = 16'habcd;
  int mismatches = 0, checks = 0;
  // Rows: index, write byte, read back, error flag
  logic [31:0] rows [8] = '{32'h14ffbb00, 32'h15121200, 32'h16343400,
    32'h17ff0000, 32'h18ff0000, 32'h12ffab00, 32'h13ffcd00,
    32'h1f550001};
  // Rows: control, start first, event source, running after
  logic [15:0] ev [5] = '{16'h8018, 16'h0019, 16'ha019, 16'h1003, 16'h0002};
  always #5 ref_clk_i = ~ref_clk_i;
  ctsl_timer dut_u (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .carrier_tick_i,
    .tx_end_i, .rx_first_nibble_i, .prev_underflow_i, .next_underflow_i,
    .prev_count_i, .trim_ref_i, .underflow_o, .running_o,
    .underflow_irq_flag_o);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Ready, error and data are taken at the rising edge that completes
  task automatic apb(logic wr, logic [7:0] idx, logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {22'h0, idx, 2'b00};
    pwdata_i <= {24'h0, wd};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Source 0 carrier, 1 tx end, 2 and 3 neighbours, 4 receive nibble
  task automatic pulse(int src, int reps);
    repeat (reps) begin
      @(posedge ref_clk_i);
      case (src)
        0: carrier_tick_i <= 1'b1;
        1: tx_end_i <= 1'b1;
        2: prev_underflow_i <= 1'b1;
        3: next_underflow_i <= 1'b1;
        default: rx_first_nibble_i <= 1'b1;
      endcase
      @(posedge ref_clk_i);
      {carrier_tick_i, tx_end_i, prev_underflow_i, next_underflow_i,
       rx_first_nibble_i} <= 5'h0;
    end
  endtask : pulse
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i][31:24], rows[i][23:16]);
      apb(1'b0, rows[i][31:24], 8'h0);
      cmp("read", {24'h0, rows[i][15:8]}, rd);
      cmp("slverr", rows[i][0], err);
    end
    apb(1'b1, CTSL_IDX_CONTROL, 8'h00);
    apb(1'b1, CTSL_IDX_RELOAD_HI, 8'h00);
    apb(1'b1, CTSL_IDX_RELOAD_LO, 8'h03);
    apb(1'b1, CTSL_IDX_START_STOP, 8'h22);
    pulse(0, 3);
    // No frame is being received, so the count bytes are safe to read
    apb(1'b0, CTSL_IDX_CNT_LO, 8'h0);
    cmp("count", 32'h0, rd);
    pulse(0, 1);
    @(negedge ref_clk_i);
    cmp("running", 32'h0, running_o);
    cmp("flag", 32'h1, underflow_irq_flag_o);
    cmp("underflow", 32'h1, underflow_o);
    apb(1'b1, CTSL_IDX_IRQ_STATUS, 8'h01);
    // The clear lands at the completion edge; look once it has settled
    @(negedge ref_clk_i);
    cmp("flag", 32'h0, underflow_irq_flag_o);
    apb(1'b1, CTSL_IDX_CONTROL, 8'h08);
    apb(1'b1, CTSL_IDX_RELOAD_LO, 8'h02);
    apb(1'b1, CTSL_IDX_START_STOP, 8'h22);
    pulse(0, 3);
    apb(1'b1, CTSL_IDX_RELOAD_LO, 8'h07);
    apb(1'b0, CTSL_IDX_CNT_LO, 8'h0);
    cmp("count", 32'h2, rd);
    cmp("running", 32'h1, running_o);
    apb(1'b0, CTSL_IDX_START_STOP, 8'h0);
    cmp("run bit", 32'h20, rd);
    // Each clock source from a fresh start, so count begins at seven
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, CTSL_IDX_CONTROL, 8'h08 | 8'(s));
      apb(1'b1, CTSL_IDX_START_STOP, 8'h02);
      apb(1'b1, CTSL_IDX_START_STOP, 8'h22);
      pulse(s == 1 ? 0 : s, s == 1 ? CTSL_DIV_RATIO : 1);
      apb(1'b0, CTSL_IDX_CNT_LO, 8'h0);
      cmp("count", 32'h6, rd);
    end
    foreach (ev[i]) begin
      apb(1'b1, CTSL_IDX_CONTROL, ev[i][15:8]);
      apb(1'b1, CTSL_IDX_START_STOP, {2'b0, ev[i][4], 5'h02});
      pulse(ev[i][3:1], 1);
      @(negedge ref_clk_i);
      cmp("running", ev[i][0], running_o);
    end
    // Trimming: first reference edge starts, the next one stops; a start
    // loads zero, so one tick shows whether the mode may underflow
    apb(1'b1, CTSL_IDX_RELOAD_LO, 8'h00);
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, CTSL_IDX_CONTROL, 8'(m << 4) | 8'h08);
      apb(1'b1, CTSL_IDX_START_STOP, 8'h02);
      apb(1'b1, CTSL_IDX_IRQ_STATUS, 8'h01);
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk_i);
        trim_ref_i <= (k != 1);
        repeat (6) @(posedge ref_clk_i);
        if (k != 1) cmp("trim run", k == 0, running_o);
        if (k == 0) begin
          pulse(0, 1);
          @(negedge ref_clk_i);
          cmp("trim flag", m == 3, underflow_irq_flag_o);
        end
      end
      trim_ref_i <= 1'b0;
    end
    // Reset in mid-run, held long enough to cover the checker's history
    apb(1'b1, CTSL_IDX_START_STOP, 8'h22);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    cmp("reset run", 32'h0, running_o);
    cmp("reset flag", 32'h0, underflow_irq_flag_o);
    apb(1'b0, CTSL_IDX_CONTROL, 8'h0);
    cmp("reset ctl", 32'h0, rd);
    end_sim();
  end
endmodule : tb_ctsl_timer
